// file: mrms_pkg.sv
package mrms_pkg;

  // port counts and stream widths
  localparam int NUM_MADI = 3;
  localparam int NUM_IN = 4;
  localparam int SAMPLE_W = 24;
  localparam int PERIOD_W = 12;

  // layout of the synchronised pin vector (index 0 is the aes input)
  localparam int LOCK_LSB = 0;
  localparam int TICK_LSB = 4;
  localparam int F96_LSB = 8;
  localparam int C56_LSB = 11;
  localparam int CS_LSB = 14;
  localparam int MK_LSB = 18;
  localparam int PIN_W = 22;

  // host channel counts: aes 2, analog 4, madi 64 per port
  localparam logic [7:0] IN_CH_REDUNDANT = 8'h42;
  localparam logic [7:0] IN_CH_FULL = 8'hc2;
  localparam logic [7:0] OUT_CH_MIRROR = 8'h46;
  localparam logic [7:0] OUT_CH_FULL = 8'hc6;
  localparam logic [6:0] MADI_CH_64 = 7'h40;
  localparam logic [6:0] MADI_CH_56 = 7'h38;

  // frame period tolerance against the reference, in clk cycles
  localparam logic [11:0] PERIOD_TOL = 12'h008;
  localparam logic [11:0] PERIOD_MAX = 12'hfff;

  // reset values
  localparam logic [1:0] ACTIVE_RESET = 2'h0;

  typedef enum logic [1:0] {
    MRMS_NO_SIGNAL,
    MRMS_LOCKED,
    MRMS_SYNCED
  } mrms_clock_state_type;

  // distance between two measured frame periods
  function automatic logic [11:0] mrms_abs_diff(input logic [11:0] a, input logic [11:0] b);
    mrms_abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : mrms_abs_diff

  // first locked standby port in ascending order, msb flags a hit
  function automatic logic [2:0] mrms_first_standby(input logic [2:0] lock,
                                                    input logic [1:0] active);
    logic [2:0] pick;
    pick = 3'h0;
    for (int k = NUM_MADI - 1; k >= 0; k--) begin
      if (lock[k] && (2'(k) != active)) begin
        pick = {1'b1, 2'(k)};
      end
    end
    mrms_first_standby = pick;
  endfunction : mrms_first_standby

endpackage : mrms_pkg

// file: mrms_stream_if.sv
interface mrms_stream_if #(parameter int W = 26);
  logic [W-1:0] data;
  logic valid;
  logic ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : mrms_stream_if

// file: mrms_pair_buffer.sv
module mrms_pair_buffer #(
  parameter int W = 26
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  mrms_stream_if.snk inPort,
  mrms_stream_if.src outPort
);

  logic [W-1:0] head;
  logic [W-1:0] spare;
  logic headValid;
  logic spareValid;
  logic [W-1:0] next_head;
  logic [W-1:0] next_spare;
  logic next_headValid;
  logic next_spareValid;
  logic push;
  logic pop;

  // ready comes from a flop so the source never waits on a long path
  assign inPort.ready = !spareValid;
  assign outPort.valid = headValid;
  assign outPort.data = head;
  assign push = inPort.valid && !spareValid;
  assign pop = headValid && outPort.ready;

  // head is the read register, spare catches a word during a stall
  always_comb begin
    next_head = head;
    next_spare = spare;
    next_headValid = headValid;
    next_spareValid = spareValid;
    if (pop && spareValid) begin
      next_head = spare;
      next_spareValid = 1'b0;
    end else if (pop || !headValid) begin
      next_head = inPort.data;
      next_headValid = push;
    end else if (push) begin
      next_spare = inPort.data;
      next_spareValid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head <= '0;
      spare <= '0;
      headValid <= 1'b0;
      spareValid <= 1'b0;
    end else if (clkEn) begin
      head <= next_head;
      spare <= next_spare;
      headValid <= next_headValid;
      spareValid <= next_spareValid;
    end
  end

endmodule : mrms_pair_buffer

// file: madi_redundancy_mirror_status.sv
// Function
// - redundancy on: host sees aes plus one madi port, 66 input channels
// - redundancy on: other madi ports stand by, switch at once to the lowest locked standby on lost signal
// - mirroring on: every port 1 output sample also goes out on ports 2 and 3
// - mirroring on: host output set shrinks to aes, four analog, one madi
// - each digital input reports no signal, locked, or locked and synchronous
// - each madi input reports 48k or 96k frame structure
// - each madi input reports 64 or 56 channels
// - status pass-through on: forward channel status and track marker bits
// - record processing: input stages in record path, output stages under loopback
// - above single speed each madi output selects 48k or native 96k frame
module madi_redundancy_mirror_status #(
  parameter int W = mrms_pkg::SAMPLE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic redundancyEnable,
  input wire logic mirrorEnable,
  input wire logic statusPassEnable,
  input wire logic record_path_processing,
  input wire logic loopbackActive,
  input wire logic highRateMode,
  input wire logic [2:0] native96kSelect,
  input wire logic [1:0] currentMadiSelect,
  input wire logic [3:0] lockPins,
  input wire logic [3:0] tickPins,
  input wire logic [2:0] frame96Pins,
  input wire logic [2:0] ch56Pins,
  input wire logic [3:0] csPins,
  input wire logic [3:0] markerPins,
  input wire logic refTick,
  input wire logic [W-1:0] mixSample,
  input wire logic [1:0] mixPort,
  input wire logic mixValid,
  output logic mixReady,
  input wire logic outReady,
  output logic [2:0][W-1:0] madiOutSample,
  output logic [2:0] madiOutValid,
  output logic [2:0] outNative96k,
  output logic [3:0][1:0] clockState,
  output logic [2:0] frame96Status,
  output logic [2:0][6:0] madiChannelCount,
  output logic [1:0] activeMadi,
  output logic failoverPulse,
  output logic [7:0] hostInChannels,
  output logic [7:0] hostOutChannels,
  output logic [3:0] statusCs,
  output logic [3:0] statusMarker,
  output logic inputStagesInRecord,
  output logic outputStagesInRecord
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---- pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [mrms_pkg::PIN_W-1:0] pinRaw;
  logic [mrms_pkg::PIN_W-1:0] sync1;
  logic [mrms_pkg::PIN_W-1:0] sync2;
  logic [mrms_pkg::PIN_W-1:0] sync3;
  logic [mrms_pkg::PIN_W-1:0] filt;
  logic [mrms_pkg::PIN_W-1:0] next_filt;
  logic [3:0] tickPrev;

  assign pinRaw = {markerPins, csPins, ch56Pins, frame96Pins, tickPins, lockPins};

  // a single-cycle glitch on a pin never reaches the filtered copy
  always_comb begin
    next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      tickPrev <= '0;
    end else if (clkEn) begin
      sync1 <= pinRaw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      tickPrev <= filt[mrms_pkg::TICK_LSB +: 4];
    end
  end

  logic [3:0] lockF;
  logic [3:0] tickRise;
  logic [2:0] madiLock;
  assign lockF = filt[mrms_pkg::LOCK_LSB +: 4];
  assign tickRise = filt[mrms_pkg::TICK_LSB +: 4] & ~tickPrev;
  assign madiLock = lockF[3:1];

  // ---- frame period measurement per input and for the reference
  logic [3:0][11:0] periodCount;
  logic [3:0][11:0] lastPeriod;
  logic [11:0] refCount;
  logic [11:0] refPeriod;
  logic [3:0][11:0] next_periodCount;
  logic [3:0][11:0] next_lastPeriod;
  logic [11:0] next_refCount;
  logic [11:0] next_refPeriod;

  // counters saturate so a dead input never wraps into a false match
  always_comb begin
    next_periodCount = periodCount;
    next_lastPeriod = lastPeriod;
    for (int i = 0; i < mrms_pkg::NUM_IN; i++) begin
      if (tickRise[i]) begin
        next_lastPeriod[i] = periodCount[i];
        next_periodCount[i] = 12'h000;
      end else if (periodCount[i] != mrms_pkg::PERIOD_MAX) begin
        next_periodCount[i] = periodCount[i] + 12'h001;
      end
    end
    next_refCount = refCount;
    next_refPeriod = refPeriod;
    if (refTick) begin
      next_refPeriod = refCount;
      next_refCount = 12'h000;
    end else if (refCount != mrms_pkg::PERIOD_MAX) begin
      next_refCount = refCount + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      periodCount <= '0;
      lastPeriod <= '0;
      refCount <= '0;
      refPeriod <= '0;
    end else if (clkEn) begin
      periodCount <= next_periodCount;
      lastPeriod <= next_lastPeriod;
      refCount <= next_refCount;
      refPeriod <= next_refPeriod;
    end
  end

  // ---- input status: clock state, frame and channel format
  logic [3:0][1:0] next_clockState;
  logic [3:0] rateMatch;
  mrms_pkg::mrms_clock_state_type state;

  always_comb begin
    next_clockState = clockState;
    rateMatch = '0;
    state = mrms_pkg::MRMS_NO_SIGNAL;
    for (int i = 0; i < mrms_pkg::NUM_IN; i++) begin
      rateMatch[i] = (refPeriod != 12'h000) && (lastPeriod[i] != 12'h000)
        && (mrms_pkg::mrms_abs_diff(lastPeriod[i], refPeriod) <= mrms_pkg::PERIOD_TOL);
      case ({lockF[i], rateMatch[i]})
        2'b10: state = mrms_pkg::MRMS_LOCKED;
        2'b11: state = mrms_pkg::MRMS_SYNCED;
        default: state = mrms_pkg::MRMS_NO_SIGNAL;
      endcase
      next_clockState[i] = state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clockState <= '0;
      frame96Status <= '0;
      madiChannelCount <= '0;
    end else if (clkEn) begin
      clockState <= next_clockState;
      frame96Status <= filt[mrms_pkg::F96_LSB +: 3];
      for (int m = 0; m < mrms_pkg::NUM_MADI; m++) begin
        madiChannelCount[m] <= filt[mrms_pkg::C56_LSB + m] ? mrms_pkg::MADI_CH_56
                                                           : mrms_pkg::MADI_CH_64;
      end
    end
  end

  // ---- redundancy: active madi port and failover
  logic [1:0] next_activeMadi;
  logic next_failoverPulse;
  logic [2:0] standbyPick;
  logic [1:0] selClamped;

  assign standbyPick = mrms_pkg::mrms_first_standby(madiLock, activeMadi);
  assign selClamped = (currentMadiSelect == 2'h3) ? 2'h0 : currentMadiSelect;

  // with no locked standby the port stays, so it comes back on its own
  always_comb begin
    next_activeMadi = activeMadi;
    next_failoverPulse = 1'b0;
    if (!redundancyEnable) begin
      next_activeMadi = selClamped;
    end else if (!madiLock[activeMadi] && standbyPick[2]) begin
      next_activeMadi = standbyPick[1:0];
      next_failoverPulse = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      activeMadi <= mrms_pkg::ACTIVE_RESET;
      failoverPulse <= 1'b0;
    end else if (clkEn) begin
      activeMadi <= next_activeMadi;
      failoverPulse <= next_failoverPulse;
    end
  end

  // ---- option decodes: channel counts, frame choice, pass-through, record path
  always_ff @(posedge clk) begin
    if (rst) begin
      hostInChannels <= mrms_pkg::IN_CH_FULL;
      hostOutChannels <= mrms_pkg::OUT_CH_FULL;
      outNative96k <= '0;
      statusCs <= '0;
      statusMarker <= '0;
      inputStagesInRecord <= 1'b0;
      outputStagesInRecord <= 1'b0;
    end else if (clkEn) begin
      hostInChannels <= redundancyEnable ? mrms_pkg::IN_CH_REDUNDANT : mrms_pkg::IN_CH_FULL;
      hostOutChannels <= mirrorEnable ? mrms_pkg::OUT_CH_MIRROR : mrms_pkg::OUT_CH_FULL;
      // native frame only at high rate
      outNative96k <= highRateMode ? native96kSelect : 3'h0;
      statusCs <= statusPassEnable ? filt[mrms_pkg::CS_LSB +: 4] : 4'h0;
      statusMarker <= statusPassEnable ? filt[mrms_pkg::MK_LSB +: 4] : 4'h0;
      inputStagesInRecord <= record_path_processing && !loopbackActive;
      outputStagesInRecord <= record_path_processing && loopbackActive;
    end
  end

  // ---- output sample path through the two-entry buffer
  mrms_stream_if #(.W(W + 2)) bufIn ();
  mrms_stream_if #(.W(W + 2)) bufOut ();

  assign bufIn.data = {mixPort, mixSample};
  assign bufIn.valid = mixValid;

  mrms_pair_buffer #(.W(W + 2)) pairBuffer (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .inPort(bufIn),
    .outPort(bufOut)
  );

  logic [2:0][W-1:0] next_madiOutSample;
  logic [2:0] next_madiOutValid;
  logic take;
  logic [1:0] takePort;
  logic [W-1:0] takeSample;

  // the output stage holds until the sink takes all three ports together
  assign bufOut.ready = (madiOutValid == 3'h0) || outReady;
  assign take = bufOut.valid && bufOut.ready;
  assign takePort = bufOut.data[W +: 2];
  assign takeSample = bufOut.data[W-1:0];

  always_comb begin
    next_madiOutSample = madiOutSample;
    next_madiOutValid = outReady ? 3'h0 : madiOutValid;
    if (take) begin
      if (mirrorEnable) begin
        // port 1 copied to 2 and 3, others dropped
        if (takePort == 2'h0) begin
          next_madiOutSample = {3{takeSample}};
          next_madiOutValid = 3'h7;
        end
      end else if (takePort != 2'h3) begin
        next_madiOutSample[takePort] = takeSample;
        next_madiOutValid[takePort] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      madiOutSample <= '0;
      madiOutValid <= '0;
      mixReady <= 1'b0;
    end else if (clkEn) begin
      madiOutSample <= next_madiOutSample;
      madiOutValid <= next_madiOutValid;
      mixReady <= 1'b1;
    end
  end

  // ---- checks
  logic [3:0] syncVec;
  always_comb begin
    for (int i = 0; i < mrms_pkg::NUM_IN; i++) begin
      syncVec[i] = (clockState[i] == 2'(mrms_pkg::MRMS_SYNCED));
    end
  end

  sequence takeMirrored;
    clkEn && take && mirrorEnable && (takePort == 2'h0);
  endsequence

  sequence lostActive;
    clkEn && redundancyEnable && !madiLock[activeMadi] && standbyPick[2];
  endsequence

  inCount_a: assert property (clkEn && redundancyEnable |=> hostInChannels == 8'h42)
    else $error("input channel count not reduced");
  failover_a: assert property (lostActive |=> failoverPulse && activeMadi != $past(activeMadi))
    else $error("no failover on lost active input");
  mirror_a: assert property (takeMirrored |=> madiOutValid == 3'h7
      && madiOutSample[1] == madiOutSample[0] && madiOutSample[2] == madiOutSample[0])
    else $error("mirror copy missing");
  outCount_a: assert property (clkEn && mirrorEnable |=> hostOutChannels == 8'h46)
    else $error("output channel count not reduced");
  syncLock_a: assert property (clkEn |=> (syncVec & ~$past(lockF)) == 4'h0)
    else $error("sync reported without lock");
  frameFmt_a: assert property (clkEn |=> frame96Status == $past(filt[10:8]))
    else $error("frame format report wrong");
  chanFmt_a: assert property (clkEn && filt[11] |=> madiChannelCount[0] == 7'h38)
    else $error("channel format report wrong");
  passGate_a: assert property (clkEn && !statusPassEnable |=> statusCs == 4'h0
      && statusMarker == 4'h0)
    else $error("status forwarded while disabled");
  recPath_a: assert property (clkEn && record_path_processing && loopbackActive
      |=> outputStagesInRecord && !inputStagesInRecord)
    else $error("record path stage choice wrong");
  native_a: assert property (clkEn && !highRateMode |=> outNative96k == 3'h0)
    else $error("native frame at single speed");
  syncTol_a: assert property (clkEn && lockF[0] && !rateMatch[0]
      |=> clockState[0] == 2'(mrms_pkg::MRMS_LOCKED))
    else $error("sync outside tolerance");
  firstPick_a: assert property (lostActive and (activeMadi != 2'h0 && madiLock[0])
      |=> activeMadi == 2'h0)
    else $error("standby order not ascending");

endmodule : madi_redundancy_mirror_status

// file: mrms_madi_partner.sv
// behavioural far side: madi and aes sources plus one sink for all outputs
module mrms_madi_partner #(
  parameter int P = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lockSet,
  input wire logic [2:0] f96Set,
  input wire logic [2:0] c56Set,
  input wire logic [3:0] bitSet,
  input wire logic [3:0] skewMask,
  input wire logic stall,
  output logic [3:0] lockPins,
  output logic [3:0] tickPins,
  output logic [2:0] frame96Pins,
  output logic [2:0] ch56Pins,
  output logic [3:0] csPins,
  output logic [3:0] markerPins,
  output logic refTick,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int skew = 0;

  // frame counters, skewed sources run 12 cycles slower than the reference
  always @(posedge clk) begin
    cnt <= (rst || cnt == P - 1) ? 0 : cnt + 1;
    skew <= (rst || skew == P + 11) ? 0 : skew + 1;
  end

  // reference and frame ticks; a source without signal sends no ticks
  always_comb begin
    refTick = (cnt == 0) && !rst;
    for (int i = 0; i < 4; i++) begin
      tickPins[i] = lockSet[i] && (skewMask[i] ? (skew < P / 2) : (cnt < P / 2));
    end
  end

  assign lockPins = lockSet;
  assign frame96Pins = f96Set;
  assign ch56Pins = c56Set;
  assign csPins = bitSet;
  assign markerPins = ~bitSet;
  // sink takes all three ports together unless told to stall
  assign outReady = !stall;
endmodule : mrms_madi_partner

// file: madi_redundancy_mirror_status_test.sv
module madi_redundancy_mirror_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic redEn = 1'b0;
  logic mirEn = 1'b0;
  logic passEn = 1'b0;
  logic recEn = 1'b0;
  logic loopEn = 1'b0;
  logic hiRate = 1'b0;
  logic [2:0] natSel = 3'h0;
  logic [1:0] curSel = 2'h0;
  logic [3:0] lockSet = 4'hf;
  logic [2:0] f96Set = 3'h0;
  logic [2:0] c56Set = 3'h0;
  logic [3:0] bitSet = 4'ha;
  logic [3:0] skewMask = 4'h0;
  logic stall = 1'b0;
  logic [23:0] mixSample = 24'h0;
  logic [1:0] mixPort = 2'h0;
  logic mixValid = 1'b0;
  logic mixReady, outReady, refTick, failoverPulse, inStg, outStg;
  logic [3:0] lockPins, tickPins, csPins, markerPins, statusCs, statusMarker;
  logic [2:0] frame96Pins, ch56Pins, madiOutValid, outNative96k, frame96Status;
  logic [2:0][23:0] madiOutSample;
  logic [3:0][1:0] clockState;
  logic [2:0][6:0] madiChannelCount;
  logic [1:0] activeMadi;
  logic [7:0] hostInChannels, hostOutChannels;
  int errCount = 0;
  int numChecks = 0;

  madi_redundancy_mirror_status DUT (.clk(clk), .rst(rst), .clkEn(clkEn),
    .redundancyEnable(redEn), .mirrorEnable(mirEn), .statusPassEnable(passEn),
    .record_path_processing(recEn), .loopbackActive(loopEn), .highRateMode(hiRate),
    .native96kSelect(natSel), .currentMadiSelect(curSel), .lockPins(lockPins),
    .tickPins(tickPins), .frame96Pins(frame96Pins), .ch56Pins(ch56Pins),
    .csPins(csPins), .markerPins(markerPins), .refTick(refTick), .mixSample(mixSample),
    .mixPort(mixPort), .mixValid(mixValid), .mixReady(mixReady), .outReady(outReady),
    .madiOutSample(madiOutSample), .madiOutValid(madiOutValid),
    .outNative96k(outNative96k), .clockState(clockState), .frame96Status(frame96Status),
    .madiChannelCount(madiChannelCount), .activeMadi(activeMadi),
    .failoverPulse(failoverPulse), .hostInChannels(hostInChannels),
    .hostOutChannels(hostOutChannels), .statusCs(statusCs), .statusMarker(statusMarker),
    .inputStagesInRecord(inStg), .outputStagesInRecord(outStg));

  mrms_madi_partner #(.P(32)) farSide (.clk(clk), .rst(rst), .lockSet(lockSet),
    .f96Set(f96Set), .c56Set(c56Set), .bitSet(bitSet), .skewMask(skewMask),
    .stall(stall), .lockPins(lockPins), .tickPins(tickPins), .frame96Pins(frame96Pins),
    .ch56Pins(ch56Pins), .csPins(csPins), .markerPins(markerPins), .refTick(refTick),
    .outReady(outReady));

  always #5 clk = ~clk;

  // compare and count; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finishTest();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finishTest

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // one word, valid left high so back to back words need no gap
  task automatic send(input logic [1:0] port, input logic [23:0] word);
    mixPort = port;
    mixSample = word;
    mixValid = 1'b1;
    @(negedge clk);
  endtask : send

  // waits bounded for the output stage, checks it, then lets the sink take it
  task automatic expectOut(input logic [2:0] mask, input logic [23:0] word);
    int k;
    k = 0;
    while (madiOutValid === 3'h0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check(madiOutValid, mask);
    for (int i = 0; i < 3; i++) begin
      if (mask[i]) check(madiOutSample[i], word);
    end
    @(negedge clk);
  endtask : expectOut

  task automatic countPulses(input int exp);
    int n;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (failoverPulse === 1'b1) n++;
    end
    check(n, exp);
  endtask : countPulses

  task automatic testOptions();
    redEn = 1'b1;
    mirEn = 1'b1;
    passEn = 1'b1;
    recEn = 1'b1;
    hiRate = 1'b1;
    natSel = 3'h5;
    cycles(12);
    check(hostInChannels, 8'h42);
    check(hostOutChannels, 8'h46);
    check({statusCs, statusMarker}, 8'ha5);
    check({inStg, outStg}, 2'h2);
    check(outNative96k, 3'h5);
    {redEn, mirEn, passEn, hiRate} = 4'h0;
    loopEn = 1'b1;
    cycles(2);
    check(hostInChannels, 8'hc2);
    check(hostOutChannels, 8'hc6);
    check({statusCs, statusMarker}, 8'h00);
    check({inStg, outStg}, 2'h1);
    check(outNative96k, 3'h0);
    // a frozen clock enable must hold the input channel count
    clkEn = 1'b0;
    redEn = 1'b1;
    cycles(3);
    check(hostInChannels, 8'hc2);
    clkEn = 1'b1;
    cycles(2);
    check(hostInChannels, 8'h42);
    redEn = 1'b0;
    cycles(2);
  endtask : testOptions

  task automatic testStatus();
    lockSet = 4'he;
    f96Set = 3'h5;
    c56Set = 3'h3;
    skewMask = 4'h8;
    cycles(256);
    check(clockState[0], mrms_pkg::MRMS_NO_SIGNAL);
    check(clockState[1], mrms_pkg::MRMS_SYNCED);
    check(clockState[2], mrms_pkg::MRMS_SYNCED);
    check(clockState[3], mrms_pkg::MRMS_LOCKED);
    check(frame96Status, 3'h5);
    check(madiChannelCount, {7'h40, 7'h38, 7'h38});
    lockSet = 4'hf;
    skewMask = 4'h0;
    cycles(256);
    check(clockState, 8'haa);
    lockSet = 4'h0;
    cycles(12);
    check(clockState, 8'h00);
    lockSet = 4'hf;
    cycles(256);
  endtask : testStatus

  task automatic testFailover();
    // the preferred port is only taken while redundancy is off
    curSel = 2'h2;
    cycles(2);
    redEn = 1'b1;
    cycles(12);
    check(activeMadi, 2'h2);
    lockSet = 4'h7;
    countPulses(1);
    check(activeMadi, 2'h0);
    lockSet = 4'h5;
    countPulses(1);
    check(activeMadi, 2'h1);
    // no locked standby left: the active port is kept
    lockSet = 4'h1;
    countPulses(0);
    check(activeMadi, 2'h1);
    redEn = 1'b0;
    curSel = 2'h0;
    lockSet = 4'hf;
    cycles(12);
  endtask : testFailover

  task automatic testStream();
    stall = 1'b1;
    send(2'h0, 24'h111111);
    mixValid = 1'b0;
    cycles(3);
    send(2'h1, 24'h222222);
    mixValid = 1'b0;
    cycles(5);
    check(madiOutValid, 3'h1);
    check(madiOutSample[0], 24'h111111);
    stall = 1'b0;
    expectOut(3'h1, 24'h111111);
    expectOut(3'h2, 24'h222222);
    send(2'h2, 24'h333333);
    mixValid = 1'b0;
    expectOut(3'h4, 24'h333333);
    send(2'h3, 24'h444444);
    mixValid = 1'b0;
    cycles(6);
    check(madiOutValid, 3'h0);
    mirEn = 1'b1;
    cycles(2);
    send(2'h0, 24'h555555);
    send(2'h0, 24'h666666);
    mixValid = 1'b0;
    expectOut(3'h7, 24'h555555);
    expectOut(3'h7, 24'h666666);
    // with mirroring, a word for port 2 is dropped
    send(2'h1, 24'h777777);
    mixValid = 1'b0;
    cycles(6);
    check(madiOutValid, 3'h0);
    mirEn = 1'b0;
  endtask : testStream

  // main sequence, inputs change at the falling edge
  initial begin
    repeat (10) @(negedge clk);
    check(hostInChannels, 8'hc2);
    check(hostOutChannels, 8'hc6);
    check(mixReady, 1'b0);
    rst = 1'b0;
    cycles(2);
    check(mixReady, 1'b1);
    testOptions();
    testStatus();
    testFailover();
    testStream();
    finishTest();
  end

  // watchdog, well beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    finishTest();
  end
endmodule : madi_redundancy_mirror_status_test
